// *** wdt_pkg.sv ***
// Constants, register map and bundle types for the watchdog timer.
// Assumes a 50 MHz system clock and a byte-addressed Avalon-MM slave port.
package wdt_pkg;

    // System clock and nominal counting rate
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned TICK_HZ = 32_768;

    // Phase accumulator for the tick divider; wraps at the clock rate
    localparam int ACC_W = 26;
    localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(TICK_HZ);
    localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(CLK_HZ);

    // Register byte offsets
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_RELOAD = 12'h000;
    localparam logic [11:0] OFS_COUNT = 12'h004;
    localparam logic [11:0] OFS_CTRL = 12'h008;
    localparam logic [11:0] OFS_ICLR = 12'h00C;
    localparam logic [11:0] OFS_RAW = 12'h010;
    localparam logic [11:0] OFS_MASKED = 12'h014;
    localparam logic [11:0] OFS_EVT_STAT = 12'h018;
    localparam logic [11:0] OFS_EVT_MASK = 12'h01C;
    localparam logic [11:0] OFS_LOCK = 12'hC00;

    // Values after reset
    localparam logic [31:0] RELOAD_RST = 32'h0FFF_FFFF;
    localparam logic [31:0] COUNT_RST = 32'h0FFF_FFFF;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [1:0] EVT_RST = 2'h0;

    // Key that opens register writes
    localparam logic [31:0] UNLOCK_KEY = 32'h1ACC_E551;

    // Field positions
    localparam int CTRL_IRQ_ENABLE_BIT_BIT = 0;
    localparam int CTRL_RESET_ENABLE_BIT_BIT = 1;
    localparam int EVT_ZERO_BIT = 0;
    localparam int EVT_DENIED_BIT = 1;
    localparam int EVT_W = 2;

    // Control fields
    typedef struct packed {
        logic reset_enable_bit;
        logic irq_enable_bit;
    } wdt_ctrl_t;

    // One bus request as seen by the slave
    typedef struct packed {
        logic [11:0] addr;
        logic rd;
        logic wr;
        logic [31:0] wdata;
        logic [3:0] be;
    } wdt_bus_req_t;

endpackage

// *** wdt_top.sv ***
// Watchdog timer: 32-bit down-counter at 32.768 kHz with interrupt,
// second-timeout reset request, key lock and an event interrupt block.
// Assumes an Avalon-MM master on ref_clk_i and a system reset controller
// that answers the reset request by pulling rst_n_i low.
//
// Summary of operation
// - 32-bit counter decrements each 32.768 kHz tick
// - Interrupt period is reload value plus one
// - Raw interrupt flag set whenever count hits zero
// - At zero reload counter and keep counting
// - Clear write clears flag, reloads; reads zero
// - Zero with flag still set requests system reset
// - Enable bit runs counter; enabling restarts from reload
// - Reset enable bit gates the reset request
// - Reload write restarts count; resets to 0FFFFFFF
// - Count register reads live count; writes ignored
// - Key opens writes, other values close them
// - Lock register at C00, resets to zero
// - Raw status register at 10, reset zero
// - Masked status register at 14, reset zero
// - Raw bit0 shows interrupt active; writes ignored
// - Lock reads one when locked, zero open
`timescale 1ns/1ps

module wdt_top #(
    parameter int unsigned TICK_STEP = wdt_pkg::TICK_HZ, // Tick rate
    parameter int unsigned TICK_WRAP = wdt_pkg::CLK_HZ // Clock rate
) (
    input wire logic ref_clk_i, // System clock, 50 MHz
    input wire logic rst_n_i, // Asynchronous reset, active low
    input wire logic [11:0] avs_address_i, // Byte address
    input wire logic avs_read_i, // Read request
    input wire logic avs_write_i, // Write request
    input wire logic [31:0] avs_writedata_i, // Write data
    input wire logic [3:0] avs_byteenable_i, // Byte lanes of write
    output logic [31:0] avs_readdata_o, // Read data
    output logic avs_waitrequest_o, // Low for the accepting cycle
    output logic wdt_irq_o, // Watchdog interrupt, level
    output logic evt_irq_o, // Event interrupt, level
    output logic wdt_rst_req_o // System reset request pulse
);

    // Reset release synchroniser; the async assert stays immediate.
    // Only the second flop feeds logic, so a release that lands close
    // to a clock edge cannot leave half the registers still in reset
    // while the other half has already started to count.
    logic rst_meta_reg;
    logic rst_sync_reg;
    wire logic rst_n;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    assign rst_n = rst_sync_reg;

    // Merge write data into an old value under the byte enables; lanes
    // left out keep their old bytes, so byte stores behave as expected
    function automatic logic [31:0] be_merge(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0] be
    );
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[8*i +: 8] = new_val[8*i +: 8];
            end
        end
        return res;
    endfunction

    // Bus request bundle
    // Qualified by waitrequest below; the bundle itself is raw
    wdt_pkg::wdt_bus_req_t req;

    assign req.addr = avs_address_i;
    assign req.rd = avs_read_i;
    assign req.wr = avs_write_i;
    assign req.wdata = avs_writedata_i;
    assign req.be = avs_byteenable_i;

    // State registers
    // Each _next value is formed by the assignments that follow
    logic [wdt_pkg::ACC_W-1:0] acc_reg;
    logic [wdt_pkg::ACC_W-1:0] acc_next;
    logic tick_reg;
    logic [31:0] reload_reg;
    logic [31:0] reload_next;
    logic [31:0] count_reg;
    logic [31:0] count_next;
    wdt_pkg::wdt_ctrl_t ctrl_reg;
    wdt_pkg::wdt_ctrl_t ctrl_next;
    logic raw_reg;
    logic raw_next;
    logic unlocked_reg;
    logic unlocked_next;
    logic [wdt_pkg::EVT_W-1:0] evt_stat_reg;
    logic [wdt_pkg::EVT_W-1:0] evt_stat_next;
    logic [wdt_pkg::EVT_W-1:0] evt_mask_reg;
    logic [wdt_pkg::EVT_W-1:0] evt_mask_next;
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic wdt_irq_reg;
    logic evt_irq_reg;
    logic rst_req_reg;
    logic rst_req_next;

    // Tick divider: a phase accumulator keeps the average rate exact,
    // trading a one-cycle jitter between ticks for no drift.
    // TICK_STEP must stay below TICK_WRAP: at most one tick per clock
    // can be produced, so a faster ratio would silently lose ticks.
    // The divider runs even while counting is stopped, so the first
    // tick after an enable may come anywhere within one tick period.
    localparam logic [wdt_pkg::ACC_W-1:0] STEP = wdt_pkg::ACC_W'(TICK_STEP);
    localparam logic [wdt_pkg::ACC_W-1:0] WRAP = wdt_pkg::ACC_W'(TICK_WRAP);
    wire logic [wdt_pkg::ACC_W:0] acc_sum;
    wire logic tick_wrap;

    assign acc_sum = {1'b0, acc_reg} + {1'b0, STEP};
    assign tick_wrap = (acc_sum >= {1'b0, WRAP});
    assign acc_next = tick_wrap ?
        wdt_pkg::ACC_W'(acc_sum - {1'b0, WRAP}) :
        acc_sum[wdt_pkg::ACC_W-1:0];

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            acc_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            acc_reg <= acc_next;
            tick_reg <= tick_wrap;
        end
    end

    // Bus access decode; an access is carried out at the edge where
    // the master sees waitrequest low, so it happens exactly once
    wire logic acc_now;
    wire logic wr_now;
    wire logic wr_ok;
    wire logic hit_reload;
    wire logic hit_count;
    wire logic hit_ctrl;
    wire logic hit_iclr;
    wire logic hit_raw;
    wire logic hit_masked;
    wire logic hit_evt_stat;
    wire logic hit_evt_mask;
    wire logic hit_lock;
    wire logic hit_any;

    assign acc_now = (req.rd | req.wr) & ~wait_reg;
    // Writes act only in the accepting cycle; a held request must not
    // write twice, since a clear or reload write restarts the count
    assign wr_now = acc_now & req.wr;
    assign hit_reload = (req.addr == wdt_pkg::OFS_RELOAD);
    assign hit_count = (req.addr == wdt_pkg::OFS_COUNT);
    assign hit_ctrl = (req.addr == wdt_pkg::OFS_CTRL);
    assign hit_iclr = (req.addr == wdt_pkg::OFS_ICLR);
    assign hit_raw = (req.addr == wdt_pkg::OFS_RAW);
    assign hit_masked = (req.addr == wdt_pkg::OFS_MASKED);
    assign hit_evt_stat = (req.addr == wdt_pkg::OFS_EVT_STAT);
    assign hit_evt_mask = (req.addr == wdt_pkg::OFS_EVT_MASK);
    assign hit_lock = (req.addr == wdt_pkg::OFS_LOCK);
    assign hit_any = hit_reload | hit_count | hit_ctrl | hit_iclr |
        hit_raw | hit_masked | hit_evt_stat | hit_evt_mask | hit_lock;

    // Writes to anything but the lock need the key first; the lock
    // itself stays writable, or a closed block could never reopen
    assign wr_ok = wr_now & unlocked_reg;

    // Write strobes per register; count, raw and masked take none.
    // Writes to unmapped offsets are acknowledged and then dropped.
    wire logic wr_reload;
    wire logic wr_ctrl;
    wire logic wr_iclr;
    wire logic wr_evt_stat;
    wire logic wr_evt_mask;
    wire logic wr_lock;
    wire logic wr_denied;
    wire logic [31:0] ctrl_wval;

    assign wr_reload = wr_ok & hit_reload;
    assign wr_ctrl = wr_ok & hit_ctrl;
    assign wr_iclr = wr_ok & hit_iclr;
    assign wr_evt_stat = wr_ok & hit_evt_stat;
    assign wr_evt_mask = wr_ok & hit_evt_mask;
    assign wr_lock = wr_now & hit_lock;
    assign wr_denied = wr_now & ~unlocked_reg & hit_any & ~hit_lock;
    assign ctrl_wval = be_merge({30'h0000_0000, ctrl_reg}, req.wdata,
        req.be);

    // Control and reload next values
    assign ctrl_next = wr_ctrl ? wdt_pkg::wdt_ctrl_t'(ctrl_wval[1:0]) :
        ctrl_reg;
    assign reload_next = wr_reload ?
        be_merge(reload_reg, req.wdata, req.be) : reload_reg;

    // Lock state: the key must arrive as a full word to open. A partial
    // store of the key closes the block like any other value, so that a
    // stray byte write can never unlock it by accident.
    assign unlocked_next = wr_lock ?
        ((req.be == 4'hF) && (req.wdata == wdt_pkg::UNLOCK_KEY)) :
        unlocked_reg;

    // Counter events
    wire logic enable_rise;
    wire logic zero_hit;

    assign enable_rise = ctrl_next.irq_enable_bit & ~ctrl_reg.irq_enable_bit;
    // Stopped while disabled, so no zero can be seen then; a count
    // left at zero by a disable is reloaded on the next enable, which
    // keeps a stale zero from firing at once
    assign zero_hit = tick_reg & ctrl_reg.irq_enable_bit &
        (count_reg == 32'h0000_0000);

    // Counter next value; a restart from the reload value wins over
    // a tick, since software just asked for a fresh period. The zero
    // test happens on the tick that finds the count already at zero,
    // so the interrupt and the reload share one cycle and no tick is
    // lost between periods.
    always_comb begin
        count_next = count_reg;
        if (wr_reload) begin
            count_next = reload_next;
        end else if (wr_iclr) begin
            count_next = reload_reg;
        end else if (enable_rise) begin
            count_next = reload_reg;
        end else if (tick_reg && ctrl_reg.irq_enable_bit) begin
            if (count_reg == 32'h0000_0000) begin
                // Zero lasts one tick, so a period is reload + 1
                count_next = reload_reg;
            end else begin
                count_next = count_reg - 32'h0000_0001;
            end
        end
    end

    // Raw flag: a new zero in the clearing cycle still sets it, so an
    // expiry is never lost to a clear that arrives a cycle too late
    assign raw_next = zero_hit | (raw_reg & ~wr_iclr);

    // A second zero with the flag still standing asks for a reset,
    // unless it was cleared in that same cycle.
    // The pulse is one cycle long, so the system reset controller has
    // to stretch it into a reset of its own.
    assign rst_req_next = zero_hit & raw_reg & ~wr_iclr &
        ctrl_reg.reset_enable_bit;

    // Event status: hardware set wins over a write-one clear. Bit 0
    // mirrors each expiry, bit 1 records a write refused while locked,
    // which lets software spot a stray access to a locked block.
    wire logic [wdt_pkg::EVT_W-1:0] evt_set;
    wire logic [wdt_pkg::EVT_W-1:0] evt_clr;
    wire logic [31:0] evt_mask_wval;

    assign evt_set[wdt_pkg::EVT_ZERO_BIT] = zero_hit;
    assign evt_set[wdt_pkg::EVT_DENIED_BIT] = wr_denied;
    assign evt_clr = wr_evt_stat ?
        (req.wdata[wdt_pkg::EVT_W-1:0] & {wdt_pkg::EVT_W{req.be[0]}}) :
        '0;
    assign evt_stat_next = evt_set | (evt_stat_reg & ~evt_clr);
    // Merge the full word, then keep only the implemented mask bits
    assign evt_mask_wval = be_merge({30'h0000_0000, evt_mask_reg},
        req.wdata, req.be);
    assign evt_mask_next = wr_evt_mask ?
        evt_mask_wval[wdt_pkg::EVT_W-1:0] : evt_mask_reg;

    // Read multiplexer; unmapped addresses and the clear register
    // read as zero, and reserved bits read as zero.
    // The data is sampled when the request is first seen, one cycle
    // before the accept, so a live count may be a tick old at most.
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (hit_reload) begin
            rdata_next = reload_reg;
        end else if (hit_count) begin
            rdata_next = count_reg;
        end else if (hit_ctrl) begin
            rdata_next = {30'h0000_0000, ctrl_reg};
        end else if (hit_raw) begin
            rdata_next = {31'h0000_0000, raw_reg};
        end else if (hit_masked) begin
            rdata_next = {31'h0000_0000,
                raw_reg & ctrl_reg.irq_enable_bit};
        end else if (hit_evt_stat) begin
            rdata_next = {30'h0000_0000, evt_stat_reg};
        end else if (hit_evt_mask) begin
            rdata_next = {30'h0000_0000, evt_mask_reg};
        end else if (hit_lock) begin
            rdata_next = {31'h0000_0000, ~unlocked_reg};
        end
    end

    // Bus handshake: waitrequest drops for one cycle per request, a
    // fixed answer that costs one wait state but needs no read pipe
    wire logic wait_next;
    wire logic rd_capture;

    assign wait_next = ~((req.rd | req.wr) & wait_reg);
    assign rd_capture = req.rd & wait_reg;

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            wait_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end else begin
            wait_reg <= wait_next;
            if (rd_capture) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    // Register file and counter; system reset restores every field.
    // The lock comes out of reset open, so boot code can program the
    // watchdog before it closes the block with a wrong key.
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            reload_reg <= wdt_pkg::RELOAD_RST;
            count_reg <= wdt_pkg::COUNT_RST;
            ctrl_reg <= wdt_pkg::CTRL_RST;
            raw_reg <= 1'b0;
            unlocked_reg <= 1'b1;
            evt_stat_reg <= wdt_pkg::EVT_RST;
            evt_mask_reg <= wdt_pkg::EVT_RST;
        end else begin
            reload_reg <= reload_next;
            count_reg <= count_next;
            ctrl_reg <= ctrl_next;
            raw_reg <= raw_next;
            unlocked_reg <= unlocked_next;
            evt_stat_reg <= evt_stat_next;
            evt_mask_reg <= evt_mask_next;
        end
    end

    // Output flops; the reset pulse lasts one cycle because the
    // zero condition only holds for the single tick cycle.
    // The interrupt uses the next enable, so a disable write drops it
    // in the same cycle as the masked status reads zero.
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            wdt_irq_reg <= 1'b0;
            evt_irq_reg <= 1'b0;
            rst_req_reg <= 1'b0;
        end else begin
            wdt_irq_reg <= raw_next & ctrl_next.irq_enable_bit;
            evt_irq_reg <= |(evt_stat_next & evt_mask_next);
            rst_req_reg <= rst_req_next;
        end
    end

    // Every output is a flop; the reset and interrupt controllers may
    // sit in other blocks, so no glitch may reach them through logic
    assign avs_readdata_o = rdata_reg;
    assign avs_waitrequest_o = wait_reg;
    assign wdt_irq_o = wdt_irq_reg;
    assign evt_irq_o = evt_irq_reg;
    assign wdt_rst_req_o = rst_req_reg;

endmodule

// *** wdt_top_asserts.sv ***
// Port-level checks for the watchdog top module.
// Assumes a master that holds each request until waitrequest is low.
`timescale 1ns/1ps
module wdt_top_asserts (
    input wire logic ref_clk_i, // Clock
    input wire logic rst_n_i, // Reset, active low
    input wire logic [11:0] avs_address_i, // Address
    input wire logic avs_read_i, // Read
    input wire logic avs_write_i, // Write
    input wire logic [31:0] avs_readdata_o, // Read data
    input wire logic avs_waitrequest_o, // Wait
    input wire logic wdt_irq_o, // Interrupt
    input wire logic wdt_rst_req_o // Reset request
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Read accepted in this cycle
    wire logic rd_ack = avs_read_i && !avs_waitrequest_o;

    req_wait_a: assert property ($rose(avs_read_i || avs_write_i)
        |-> avs_waitrequest_o) else $error("request taken at once");
    ack_next_a: assert property ($rose(avs_read_i || avs_write_i)
        |=> !avs_waitrequest_o) else $error("no answer after one cycle");
    ack_one_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low two cycles");
    rst_pulse_a: assert property (
        wdt_rst_req_o |=> !wdt_rst_req_o) else $error("reset pulse long");
    rst_cause_a: assert property (
        wdt_rst_req_o |-> wdt_irq_o) else $error("reset without interrupt");
    clr_read_a: assert property (
        rd_ack && avs_address_i == wdt_pkg::OFS_ICLR
        |-> avs_readdata_o == 32'h0) else $error("clear reads nonzero");
    raw_rsvd_a: assert property (
        rd_ack && avs_address_i == wdt_pkg::OFS_RAW
        |-> avs_readdata_o[31:1] == 31'h0) else $error("raw upper bits");
    mask_rsvd_a: assert property (
        rd_ack && avs_address_i == wdt_pkg::OFS_MASKED
        |-> avs_readdata_o[31:1] == 31'h0) else $error("masked upper bits");
    lock_rsvd_a: assert property (
        rd_ack && avs_address_i == wdt_pkg::OFS_LOCK
        |-> avs_readdata_o[31:1] == 31'h0) else $error("lock upper bits");
endmodule

bind wdt_top wdt_top_asserts u_wdt_chk (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .wdt_irq_o(wdt_irq_o),
    .wdt_rst_req_o(wdt_rst_req_o));

// *** wdt_sys_rst.sv ***
// System reset controller model facing the watchdog reset request.
// Assumes the request is a pulse on the system clock.
`timescale 1ns/1ps
module wdt_sys_rst #(
    parameter int HOLD = 4 // Cycles the reset stays low
) (
    input wire logic ref_clk_i, // System clock
    input wire logic rst_req_i, // Reset request pulse
    output logic rst_n_o // System reset, active low
);
    int cnt = 0;
    // Stretch the pulse so the two-flop release sees a real reset
    always @(posedge ref_clk_i) begin
        if (rst_req_i === 1'b1) begin
            cnt <= HOLD;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
    assign rst_n_o = (cnt == 0);
endmodule

// *** watchdog_timer_bench.sv ***
// Self-checking bench for the watchdog top over Avalon-MM.
// Assumes a fast tick (one per four clocks) to keep periods short.
`timescale 1ns/1ps
module watchdog_timer_bench;
    localparam int STEP = 1;
    localparam int WRAP = 4;
    logic ref_clk_i = 1'b0;
    logic bench_rst_n = 1'b0;
    wire logic sys_rst_n;
    wire logic rst_n_i = bench_rst_n & sys_rst_n;
    logic [11:0] avs_address_i = 12'h000;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0] avs_byteenable_i = 4'hF;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o, wdt_irq_o, evt_irq_o, wdt_rst_req_o;
    int error_cnt = 0;
    int samples_checked = 0;
    int rst_seen = 0;
    int n, per;
    logic [31:0] seed = 32'h0000DD8E;
    logic [31:0] t, l, c;

    wdt_top #(.TICK_STEP(STEP), .TICK_WRAP(WRAP)) DUT (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .wdt_irq_o(wdt_irq_o),
        .evt_irq_o(evt_irq_o), .wdt_rst_req_o(wdt_rst_req_o));
    wdt_sys_rst u_rst (.ref_clk_i(ref_clk_i), .rst_req_i(wdt_rst_req_o),
        .rst_n_o(sys_rst_n));

    // 50 MHz clock
    initial begin
        forever #10 ref_clk_i = ~ref_clk_i;
    end
    // Count reset requests seen at the port
    always @(posedge ref_clk_i) begin
        if (wdt_rst_req_o === 1'b1) rst_seen++;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Clocks from reload to interrupt: reload plus one ticks
    function automatic int period_clks(input logic [31:0] v);
        return (int'(v) + 1) * WRAP / STEP;
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One bus access; one idle edge after it avoids re-driving in a step
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k = 0;
        avs_address_i <= a;
        avs_write_i <= w;
        avs_read_i <= !w;
        avs_writedata_i <= d;
        do begin
            @(posedge ref_clk_i);
            k++;
        end while (avs_waitrequest_o !== 1'b0 && k < 50);
        t = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        if (k >= 50) chk("waitrequest", 32'h0, 32'h1);
        @(posedge ref_clk_i);
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk($sformatf("read %h", a), e, t);
    endtask
    task automatic wait_irq();
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (wdt_irq_o !== 1'b1 && n < 4000);
    endtask
    task automatic in_range(input string nm, input int v, lo, hi);
        chk(nm, 32'h1, {31'h0, v >= lo && v <= hi});
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        error_cnt++;
        finish_test();
    end

    initial begin
        repeat (8) @(posedge ref_clk_i);
        bench_rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        rc(wdt_pkg::OFS_RELOAD, wdt_pkg::RELOAD_RST);
        rc(wdt_pkg::OFS_COUNT, wdt_pkg::COUNT_RST);
        rc(wdt_pkg::OFS_CTRL, 32'h0);
        rc(wdt_pkg::OFS_ICLR, 32'h0);
        rc(wdt_pkg::OFS_RAW, 32'h0);
        rc(wdt_pkg::OFS_MASKED, 32'h0);
        rc(wdt_pkg::OFS_LOCK, 32'h0);
        rc(12'h100, 32'h0);
        // Wrong key closes writes, right key opens them
        c = rnd();
        if (c == wdt_pkg::UNLOCK_KEY) c = c ^ 32'h1;
        bus(1'b1, wdt_pkg::OFS_LOCK, c);
        rc(wdt_pkg::OFS_LOCK, 32'h1);
        bus(1'b1, wdt_pkg::OFS_RELOAD, rnd());
        rc(wdt_pkg::OFS_RELOAD, wdt_pkg::RELOAD_RST);
        // A key stored through only three lanes keeps the block closed
        avs_byteenable_i <= 4'h7;
        bus(1'b1, wdt_pkg::OFS_LOCK, wdt_pkg::UNLOCK_KEY);
        avs_byteenable_i <= 4'hF;
        rc(wdt_pkg::OFS_LOCK, 32'h1);
        bus(1'b1, wdt_pkg::OFS_LOCK, wdt_pkg::UNLOCK_KEY);
        rc(wdt_pkg::OFS_LOCK, 32'h0);
        bus(1'b1, wdt_pkg::OFS_COUNT, rnd());
        rc(wdt_pkg::OFS_COUNT, wdt_pkg::COUNT_RST);
        // Short random reload, counter still stopped
        l = 32'h6 + (rnd() & 32'h7);
        per = period_clks(l);
        bus(1'b1, wdt_pkg::OFS_RELOAD, l);
        rc(wdt_pkg::OFS_COUNT, l);
        bus(1'b1, wdt_pkg::OFS_CTRL, 32'h1);
        wait_irq();
        in_range("first period", n, per - 6, per + 6);
        bus(1'b0, wdt_pkg::OFS_COUNT, 32'h0);
        in_range("count reloaded", int'(t), int'(l) - 2, int'(l));
        rc(wdt_pkg::OFS_RAW, 32'h1);
        rc(wdt_pkg::OFS_MASKED, 32'h1);
        bus(1'b1, wdt_pkg::OFS_RAW, 32'h0);
        rc(wdt_pkg::OFS_RAW, 32'h1);
        bus(1'b1, wdt_pkg::OFS_ICLR, rnd());
        rc(wdt_pkg::OFS_RAW, 32'h0);
        bus(1'b1, wdt_pkg::OFS_ICLR, rnd());
        wait_irq();
        in_range("period after clear", n, per - 6, per + 6);
        // Second zero with flag set but reset disabled
        repeat (2 * per + 8) @(posedge ref_clk_i);
        chk("no reset", 32'h0, rst_seen);
        bus(1'b1, wdt_pkg::OFS_CTRL, 32'h0);
        bus(1'b0, wdt_pkg::OFS_COUNT, 32'h0);
        c = t;
        repeat (20) @(posedge ref_clk_i);
        rc(wdt_pkg::OFS_COUNT, c);
        rc(wdt_pkg::OFS_RAW, 32'h1);
        rc(wdt_pkg::OFS_MASKED, 32'h0);
        chk("irq masked", 32'h0, wdt_irq_o);
        // Event interrupt: expiry and refused write seen, then cleared
        rc(wdt_pkg::OFS_EVT_STAT, 32'h3);
        chk("evt masked", 32'h0, evt_irq_o);
        bus(1'b1, wdt_pkg::OFS_EVT_MASK, 32'h3);
        chk("evt raised", 32'h1, evt_irq_o);
        bus(1'b1, wdt_pkg::OFS_EVT_STAT, 32'hFF);
        chk("evt cleared", 32'h0, evt_irq_o);
        rc(wdt_pkg::OFS_EVT_STAT, 32'h0);
        // Served periods cause no reset, a missed one does
        bus(1'b1, wdt_pkg::OFS_ICLR, 32'h0);
        bus(1'b1, wdt_pkg::OFS_CTRL, 32'h3);
        wait_irq();
        in_range("restart period", n, per - 6, per + 6);
        repeat (2) begin
            bus(1'b1, wdt_pkg::OFS_ICLR, rnd());
            wait_irq();
        end
        chk("served", 32'h0, rst_seen);
        n = 0;
        while (rst_seen == 0 && n < 2 * per + 20) begin
            @(posedge ref_clk_i);
            n++;
        end
        chk("reset request", 32'h1, rst_seen);
        // Wait for the system reset to start, then for its release
        while (rst_seen != 0 && rst_n_i !== 1'b0) @(posedge ref_clk_i);
        while (rst_n_i !== 1'b1) @(posedge ref_clk_i);
        repeat (4) @(posedge ref_clk_i);
        rc(wdt_pkg::OFS_RELOAD, wdt_pkg::RELOAD_RST);
        rc(wdt_pkg::OFS_CTRL, 32'h0);
        finish_test();
    end
endmodule
